//--- logic/fault_record_pkg.sv
// shared constants, types and layouts of the fault record logger
// assumes a 50 MHz device clock and a word-wide flash macro outside the block
package fault_record_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int PROG_TIME_NS = 46000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RTC_TICK_HZ = 65536;

  // ****************************************
  // record layout and flash map
  // ****************************************
  localparam int RECORD_BYTES = 64;
  localparam int UNIT_BYTES = 4;
  localparam int UNITS_PER_REC = RECORD_BYTES / UNIT_BYTES;
  localparam int RECS_PER_PAGE = 8;
  localparam int PAGE_BYTES = RECORD_BYTES * RECS_PER_PAGE;
  localparam int SINGLE_PAGES = 4;
  localparam int CYCLIC_PAGES = 5;
  localparam int MAX_RECORDS = 32;
  localparam int CYCLIC_SLOTS = CYCLIC_PAGES * RECS_PER_PAGE;
  localparam int STATUS_WORDS = UNITS_PER_REC - 3;
  localparam int STATUS_BITS = STATUS_WORDS * 32;
  localparam int TIME_BITS = 48;
  localparam logic [15:0] RECORD_BASE = 16'h1000;
  localparam logic [15:0] PWRCNT_ADDR = 16'h0ffc;
  localparam logic [15:0] PWRCNT_MAX = 16'hffff;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] ID_RESET = 32'h0000_0000;
  localparam logic [47:0] TIME_RESET = 48'h0000_0000_0000;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic prog;
    logic erase;
    logic read;
    logic [15:0] addr;
    logic [31:0] wdata;
  } flash_cmd_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] last_index;
  } record_summary_info_s;

  typedef struct packed {
    logic trig;
    logic [31:0] id;
  } inter_device_link_s;

endpackage

//--- logic/unit_timer.sv
// one-shot cycle timer used to pace flash program and erase operations
// assumes start is a single-cycle pulse and cycles is at least one
`timescale 1ns/1ps
module unit_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [31:0] i_cycles,
  output logic o_busy,
  output logic o_done
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // count down; done fires on the cycle the count leaves one
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (i_start) begin
      nxt_cnt = i_cycles;
    end else if (cnt_ff != 32'h0000_0000) begin
      nxt_cnt = cnt_ff - 32'h0000_0001;
      nxt_done = (cnt_ff == 32'h0000_0001);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign o_busy = (cnt_ff != 32'h0000_0000);
  assign o_done = done_ff;
endmodule // unit_timer

//--- logic/rtc_counter.sv
// real-time counter in 1/65536 s units, loadable with an epoch value
// assumes reset is asserted whenever the device loses power
`timescale 1ns/1ps
module rtc_counter
  import fault_record_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [fault_record_pkg::TIME_BITS-1:0] i_value,
  output logic [fault_record_pkg::TIME_BITS-1:0] o_time
);
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic [TIME_BITS-1:0] time_ff;
  logic [TIME_BITS-1:0] nxt_time;
  logic [31:0] acc_sum;

  // fractional accumulator: exact average rate, since the clock is no multiple of the tick
  always_comb begin
    acc_sum = acc_ff + 32'(RTC_TICK_HZ);
    nxt_acc = acc_sum;
    nxt_time = time_ff;
    if (acc_sum >= 32'(CLK_HZ)) begin
      nxt_acc = acc_sum - 32'(CLK_HZ);
      nxt_time = time_ff + 48'h0000_0000_0001;
    end
    if (i_load) begin
      nxt_time = i_value;
      nxt_acc = 32'h0000_0000;
    end
  end

  // power loss resets the count to zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= 32'h0000_0000;
      time_ff <= TIME_RESET;
    end else begin
      acc_ff <= nxt_acc;
      time_ff <= nxt_time;
    end
  end

  assign o_time = time_ff;
endmodule // rtc_counter

//--- logic/fault_record_logger.sv
// fault record logger: snapshot capture, deferred flash commit, record bookkeeping
// assumes a flash macro that takes single-cycle prog/erase/read strobes and
// returns read data with a valid pulse; power-up loads nonvolatile values on pins
`timescale 1ns/1ps
module fault_record_logger #(
  parameter int ERASE_CYCLES = 1_000_000
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // sequencing engine
  input wire logic i_rec_loop,
  input wire logic i_rec_enter,
  input wire logic i_supply_loss,
  input wire logic i_state_enter,
  input wire logic i_enter_done,
  input wire logic [fault_record_pkg::STATUS_BITS-1:0] i_status,
  // configuration
  input wire logic i_cyclic_mode,
  input wire logic i_ts_enable,
  // inter-device link
  input wire fault_record_pkg::inter_device_link_s i_link,
  output fault_record_pkg::inter_device_link_s o_link,
  // host side
  input wire logic i_epoch_set,
  input wire logic [fault_record_pkg::TIME_BITS-1:0] i_epoch_time,
  input wire logic i_erase_records,
  input wire logic i_rd_req,
  input wire logic [5:0] i_rd_index,
  input wire logic [3:0] i_rd_word,
  output logic [31:0] o_record_readout,
  output logic o_rd_valid,
  output fault_record_pkg::record_summary_info_s o_record_summary_info,
  output logic [15:0] o_power_up_count,
  output logic [fault_record_pkg::TIME_BITS-1:0] o_rtc_time,
  output logic o_busy,
  output logic o_pending,
  output logic o_full,
  // nonvolatile values presented at power-up
  input wire logic [15:0] i_nv_pwr_cnt,
  input wire logic [7:0] i_nv_rec_count,
  input wire logic [7:0] i_nv_last_index,
  // flash macro
  output fault_record_pkg::flash_cmd_s o_flash,
  input wire logic i_fl_rd_valid,
  input wire logic [31:0] i_fl_rdata
);
  import fault_record_pkg::*;

  // ****************************************
  // reset synchroniser
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  // release through two flops so the whole block leaves reset on one edge
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  typedef enum logic [2:0] {
    ST_PUP_LOAD, ST_PUP_PROG, ST_IDLE, ST_PROG, ST_ERASE_PAGE, ST_ERASE_ALL, ST_READ
  } state_e;

  // byte address of one 4-byte unit of a record slot
  function automatic logic [15:0] rec_addr(input logic [5:0] slot, input logic [3:0] unit);
    rec_addr = RECORD_BASE + {slot, 6'h00} + {10'h000, unit, 2'b00};
  endfunction

  // byte address of a record page
  function automatic logic [15:0] page_addr(input logic [2:0] page);
    page_addr = RECORD_BASE + {4'h0, page, 9'h000};
  endfunction

  logic tmr_start;
  logic [31:0] tmr_cycles;
  logic tmr_done;
  logic [TIME_BITS-1:0] rtc_time;

  unit_timer u_timer (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_sync_ff),
    .i_start(tmr_start),
    .i_cycles(tmr_cycles),
    .o_busy(),
    .o_done(tmr_done)
  );

  rtc_counter u_rtc (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_sync_ff),
    .i_load(i_epoch_set),
    .i_value(i_epoch_time),
    .o_time(rtc_time)
  );

  // ****************************************
  // state
  // ****************************************
  state_e state_ff, nxt_state;
  logic [3:0] unit_ff, nxt_unit;
  logic [5:0] slot_ff, nxt_slot;
  logic [7:0] count_ff, nxt_count;
  logic [7:0] last_ff, nxt_last;
  logic [15:0] pcount_ff, nxt_pcount;
  logic [2:0] page_ff, nxt_page;
  logic [31:0] seq_id_ff, nxt_seq_id;
  logic [STATUS_BITS-1:0] snap_ff, nxt_snap;
  logic [31:0] snap_id_ff, nxt_snap_id;
  logic [TIME_BITS-1:0] stamp_ff, nxt_stamp;
  logic pend_ff, nxt_pend;
  logic wait_ff, nxt_wait;
  logic ready_ff, nxt_ready;
  logic go_ff, nxt_go;
  flash_cmd_s fl_ff, nxt_fl;
  inter_device_link_s link_ff, nxt_link;
  logic [31:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic [31:0] word;
  logic [3:0] unit_next;
  logic [5:0] slot_inc;
  logic local_trig;
  logic full;

  // single mode holds 32 at most; cyclic wraps over five pages of slots
  always_comb begin
    full = !i_cyclic_mode && (count_ff >= 8'(MAX_RECORDS));
    if (i_cyclic_mode) begin
      slot_inc = (slot_ff == 6'(CYCLIC_SLOTS - 1)) ? 6'h00 : slot_ff + 6'h01;
    end else begin
      slot_inc = slot_ff + 6'h01;
    end
    local_trig = i_rec_loop || i_rec_enter || i_supply_loss;
  end

  // record word for the unit issued next: id, counter, stamp, then status
  always_comb begin
    unit_next = unit_ff + 4'h1;
    unique case (unit_next)
      4'h0: word = snap_id_ff;
      4'h1: word = {pcount_ff, stamp_ff[47:32]};
      4'h2: word = stamp_ff[31:0];
      default: word = snap_ff[(32'(unit_next) - 3) * 32 +: 32];
    endcase
  end

  // ****************************************
  // trigger capture and commit timing
  // ****************************************
  always_comb begin
    nxt_snap = snap_ff;
    nxt_snap_id = snap_id_ff;
    nxt_seq_id = seq_id_ff;
    nxt_pend = pend_ff;
    nxt_wait = wait_ff;
    nxt_ready = ready_ff;
    nxt_go = go_ff;
    nxt_link = '0;
    if (!pend_ff && local_trig) begin
      nxt_snap = i_status;
      nxt_snap_id = seq_id_ff + 32'h0000_0001;
      nxt_seq_id = seq_id_ff + 32'h0000_0001;
      nxt_pend = 1'b1;
      nxt_link.trig = 1'b1;
      nxt_link.id = seq_id_ff + 32'h0000_0001;
      nxt_go = i_supply_loss;
      nxt_ready = i_rec_enter && !i_supply_loss;
      nxt_wait = i_rec_loop && !i_rec_enter && !i_supply_loss;
    end else if (!pend_ff && i_link.trig) begin
      // a partner's event: adopt its id so merged records line up
      nxt_snap = i_status;
      nxt_snap_id = i_link.id;
      nxt_seq_id = i_link.id;
      nxt_pend = 1'b1;
      nxt_go = 1'b1;
    end else if (pend_ff) begin
      // the snapshot stays frozen; only the commit point advances
      if (wait_ff && i_state_enter) begin
        nxt_wait = 1'b0;
        nxt_ready = 1'b1;
      end
      if (ready_ff && i_enter_done) begin
        nxt_ready = 1'b0;
        nxt_go = 1'b1;
      end
    end
    // commit finished or refused: release the snapshot buffer
    if (pend_ff && ((state_ff == ST_PROG && tmr_done && unit_ff == 4'hf) ||
                    (state_ff == ST_IDLE && go_ff && full))) begin
      nxt_pend = 1'b0;
      nxt_go = 1'b0;
    end
  end

  // ****************************************
  // flash sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_unit = unit_ff;
    nxt_slot = slot_ff;
    nxt_count = count_ff;
    nxt_last = last_ff;
    nxt_pcount = pcount_ff;
    nxt_page = page_ff;
    nxt_stamp = stamp_ff;
    nxt_fl = '0;
    nxt_fl.addr = fl_ff.addr;
    nxt_fl.wdata = fl_ff.wdata;
    nxt_rd_data = rd_data_ff;
    nxt_rd_valid = 1'b0;
    tmr_start = 1'b0;
    tmr_cycles = 32'(PROG_CYCLES);
    unique case (state_ff)
      ST_PUP_LOAD: begin
        // power-up: bump the stored counter, saturating at its top
        nxt_pcount = (i_nv_pwr_cnt == PWRCNT_MAX) ? PWRCNT_MAX
                     : i_nv_pwr_cnt + 16'h0001;
        nxt_count = i_nv_rec_count;
        nxt_last = i_nv_last_index;
        nxt_slot = (i_nv_rec_count == 8'h00) ? 6'h00 : i_nv_last_index[5:0] + 6'h01;
        nxt_fl.prog = 1'b1;
        nxt_fl.addr = PWRCNT_ADDR;
        nxt_fl.wdata = {16'h0000, nxt_pcount};
        tmr_start = 1'b1;
        nxt_state = ST_PUP_PROG;
      end
      ST_PUP_PROG: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (go_ff && !full) begin
          nxt_stamp = i_ts_enable ? rtc_time : TIME_RESET;
          nxt_unit = 4'h0;
          nxt_state = ST_PROG;
          tmr_start = 1'b1;
          nxt_fl.prog = 1'b1;
          nxt_fl.addr = rec_addr(slot_ff, 4'h0);
          nxt_fl.wdata = snap_id_ff;
        end else if (i_erase_records) begin
          nxt_page = 3'h0;
          nxt_state = ST_ERASE_ALL;
          nxt_fl.erase = 1'b1;
          nxt_fl.addr = page_addr(3'h0);
          tmr_start = 1'b1;
          tmr_cycles = 32'(ERASE_CYCLES);
        end else if (i_rd_req) begin
          nxt_fl.read = 1'b1;
          nxt_fl.addr = rec_addr(i_rd_index, i_rd_word);
          nxt_state = ST_READ;
        end
      end
      ST_PROG: begin
        if (tmr_done && unit_ff != 4'hf) begin
          // next 4-byte unit only after the previous one has had its full time
          nxt_unit = unit_ff + 4'h1;
          nxt_fl.prog = 1'b1;
          nxt_fl.addr = rec_addr(slot_ff, nxt_unit);
          tmr_start = 1'b1;
          nxt_state = ST_PROG;
        end else if (tmr_done) begin
          nxt_count = (count_ff >= 8'(MAX_RECORDS)) ? 8'(MAX_RECORDS)
                      : count_ff + 8'h01;
          nxt_last = {2'b00, slot_ff};
          nxt_slot = slot_inc;
          nxt_state = ST_IDLE;
          if (i_cyclic_mode && slot_ff[2:0] == 3'(RECS_PER_PAGE - 1)) begin
            nxt_page = slot_inc[5:3];
            nxt_fl.erase = 1'b1;
            nxt_fl.addr = page_addr(slot_inc[5:3]);
            tmr_start = 1'b1;
            tmr_cycles = 32'(ERASE_CYCLES);
            nxt_state = ST_ERASE_PAGE;
          end
        end
      end
      ST_ERASE_PAGE: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ERASE_ALL: begin
        // wipe all five pages so either mode starts clean
        if (tmr_done && page_ff != 3'(CYCLIC_PAGES - 1)) begin
          nxt_page = page_ff + 3'h1;
          nxt_fl.erase = 1'b1;
          nxt_fl.addr = page_addr(nxt_page);
          tmr_start = 1'b1;
          tmr_cycles = 32'(ERASE_CYCLES);
        end else if (tmr_done) begin
          nxt_count = 8'h00;
          nxt_last = 8'h00;
          nxt_slot = 6'h00;
          nxt_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (i_fl_rd_valid) begin
          nxt_rd_data = i_fl_rdata;
          nxt_rd_valid = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    endcase
    // data must follow the unit being started, not the one just finished
    if (state_ff == ST_PROG && unit_ff != 4'hf && tmr_done) begin
      nxt_fl.wdata = word;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_PUP_LOAD;
      unit_ff <= 4'h0;
      slot_ff <= 6'h00;
      count_ff <= 8'h00;
      last_ff <= 8'h00;
      pcount_ff <= 16'h0000;
      page_ff <= 3'h0;
      seq_id_ff <= ID_RESET;
      snap_ff <= '0;
      snap_id_ff <= ID_RESET;
      stamp_ff <= TIME_RESET;
      pend_ff <= 1'b0;
      wait_ff <= 1'b0;
      ready_ff <= 1'b0;
      go_ff <= 1'b0;
      fl_ff <= '0;
      link_ff <= '0;
      rd_data_ff <= 32'h0000_0000;
      rd_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      unit_ff <= nxt_unit;
      slot_ff <= nxt_slot;
      count_ff <= nxt_count;
      last_ff <= nxt_last;
      pcount_ff <= nxt_pcount;
      page_ff <= nxt_page;
      seq_id_ff <= nxt_seq_id;
      snap_ff <= nxt_snap;
      snap_id_ff <= nxt_snap_id;
      stamp_ff <= nxt_stamp;
      pend_ff <= nxt_pend;
      wait_ff <= nxt_wait;
      ready_ff <= nxt_ready;
      go_ff <= nxt_go;
      fl_ff <= nxt_fl;
      link_ff <= nxt_link;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_flash = fl_ff;
  assign o_link = link_ff;
  assign o_record_readout = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_record_summary_info.count = count_ff;
  assign o_record_summary_info.last_index = last_ff;
  assign o_power_up_count = pcount_ff;
  assign o_rtc_time = rtc_time;
  assign o_busy = (state_ff != ST_IDLE);
  assign o_pending = pend_ff;
  assign o_full = full;
endmodule // fault_record_logger

//--- verification/fault_record_logger_properties.sv
// checker of the fault record logger port behaviour
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module fault_record_logger_properties
  import fault_record_pkg::*;
#(
  parameter int ERASE_CYCLES = 1_000_000
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_rec_loop,
  input wire logic i_rec_enter,
  input wire logic i_supply_loss,
  input wire logic i_enter_done,
  input wire logic i_cyclic_mode,
  input wire fault_record_pkg::inter_device_link_s i_link,
  input wire fault_record_pkg::inter_device_link_s o_link,
  input wire logic o_pending,
  input wire logic o_busy,
  input wire logic o_full,
  input wire logic o_rd_valid,
  input wire logic i_fl_rd_valid,
  input wire fault_record_pkg::flash_cmd_s o_flash,
  input wire fault_record_pkg::record_summary_info_s o_record_summary_info,
  input wire logic [15:0] o_power_up_count
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic [11:0] gap_ff;
  logic [11:0] nxt_gap;
  logic arm_ff;
  logic nxt_arm;
  logic local_trig;
  assign local_trig = i_rec_loop || i_rec_enter || i_supply_loss;
  // ****************************************
  // helper state
  // ****************************************
  // gap saturates so long idle spans never wrap into a false short gap
  always_comb begin
    nxt_gap = o_flash.prog ? 12'h000 : (gap_ff == 12'hfff ? gap_ff : gap_ff + 12'h001);
    nxt_arm = (i_rec_enter && !o_pending) ? 1'b1 : (o_pending ? arm_ff : 1'b0);
  end
  // registers only
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_ff <= 12'hfff;
      arm_ff <= 1'b0;
    end else begin
      gap_ff <= nxt_gap;
      arm_ff <= nxt_arm;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_enter_commit;
    arm_ff && i_enter_done && !o_busy && !o_full;
  endsequence
  sequence s_unit_start;
    o_flash.prog;
  endsequence
  a_trig_pending: assert property ((local_trig || i_link.trig) && !o_pending |=> o_pending)
    else $error("trigger did not raise pending");
  a_link_echo: assert property (local_trig && !o_pending |=> o_link.trig)
    else $error("local trigger not echoed on link");
  a_unit_spacing: assert property (s_unit_start |-> gap_ff >= 12'd2299)
    else $error("flash units closer than one program time");
  a_full_drop: assert property (o_full && i_supply_loss && !o_pending |-> ##1 (!o_flash.prog)[*8])
    else $error("record written while full");
  a_full_flag: assert property (o_full == (!i_cyclic_mode && o_record_summary_info.count >= 8'd32))
    else $error("full flag wrong");
  a_read_answer: assert property (i_fl_rd_valid |=> o_rd_valid)
    else $error("readout valid missing");
  a_count_cap: assert property (o_record_summary_info.count <= 8'd32)
    else $error("record count above 32");
  a_enter_commit: assert property (s_enter_commit |-> ##2 s_unit_start)
    else $error("enter record not committed at enter end");
  a_pwrcnt_hold: assert property (!o_busy |-> $stable(o_power_up_count))
    else $error("power-up count moved at run time");
endmodule // fault_record_logger_properties

bind fault_record_logger fault_record_logger_properties #(.ERASE_CYCLES(ERASE_CYCLES)) i_props (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_rec_loop(i_rec_loop),
  .i_rec_enter(i_rec_enter), .i_supply_loss(i_supply_loss), .i_enter_done(i_enter_done),
  .i_cyclic_mode(i_cyclic_mode), .i_link(i_link), .o_link(o_link), .o_pending(o_pending),
  .o_busy(o_busy), .o_full(o_full), .o_rd_valid(o_rd_valid), .i_fl_rd_valid(i_fl_rd_valid),
  .o_flash(o_flash), .o_record_summary_info(o_record_summary_info),
  .o_power_up_count(o_power_up_count));

//--- verification/flash_model.sv
// behavioural flash macro answering the logger's strobes
// assumes single-cycle strobes; read answer comes two cycles later
`timescale 1ns/1ps
module flash_model
  import fault_record_pkg::*;
(
  input wire logic i_clk,
  input wire fault_record_pkg::flash_cmd_s i_cmd,
  output logic o_valid,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [int];
  logic [15:0] rd_addr;
  logic rd_ff;
  initial begin
    o_valid = 1'b0;
    o_rdata = 32'h0000_0000;
    rd_ff = 1'b0;
    rd_addr = 16'h0000;
  end
  // data line inverts its own previous value every cycle outside the answer cycle
  always @(posedge i_clk) begin
    if (i_cmd.prog) mem[int'(i_cmd.addr)] = i_cmd.wdata;
    if (i_cmd.erase) begin
      for (int k = 0; k < 128; k++) mem[int'(i_cmd.addr) + 4 * k] = 32'hffff_ffff;
    end
    o_valid <= rd_ff;
    o_rdata <= rd_ff ? (mem.exists(int'(rd_addr)) ? mem[int'(rd_addr)] : 32'hffff_ffff) : ~o_rdata;
    rd_ff <= i_cmd.read;
    if (i_cmd.read) rd_addr <= i_cmd.addr;
  end
endmodule // flash_model

//--- verification/fault_record_logger_test.sv
// self-checking bench of the fault record logger
// assumes the flash model and the bound checker beside the design
`timescale 1ns/1ps
module fault_record_logger_test;
  import fault_record_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rec_enter = 1'b0, supply_loss = 1'b0, enter_done = 1'b0, cyclic = 1'b0, ts_en = 1'b1;
  logic epoch_set = 1'b0, rd_req = 1'b0, fl_valid;
  logic rec_loop = 1'b0, state_enter = 1'b0, erase_rec = 1'b0;
  logic [5:0] rd_index = 6'h00;
  logic [3:0] rd_word = 4'h0;
  logic [47:0] epoch = 48'h0000_0000_0000;
  logic [STATUS_BITS-1:0] status = {13{32'h1234_5678}};
  logic [15:0] nv_pwr = 16'h0041;
  logic [7:0] nv_cnt = 8'h06, nv_last = 8'h05;
  logic [31:0] readout, fl_rdata;
  logic rd_valid, busy, pending, full;
  logic [47:0] rtc;
  logic [15:0] pwr_cnt;
  inter_device_link_s link_in = '0;
  inter_device_link_s link_out;
  record_summary_info_s info;
  flash_cmd_s flash;
  int err_total = 0, num_checks = 0, prog_cnt = 0;
  logic [15:0] first_addr, erase_addr;
  always #10 clk = ~clk;
  fault_record_logger #(.ERASE_CYCLES(8)) i_fault_record_logger (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_rec_loop(rec_loop), .i_rec_enter(rec_enter),
    .i_supply_loss(supply_loss), .i_state_enter(state_enter), .i_enter_done(enter_done),
    .i_status(status), .i_cyclic_mode(cyclic), .i_ts_enable(ts_en), .i_link(link_in),
    .o_link(link_out), .i_epoch_set(epoch_set), .i_epoch_time(epoch),
    .i_erase_records(erase_rec), .i_rd_req(rd_req), .i_rd_index(rd_index), .i_rd_word(rd_word),
    .o_record_readout(readout), .o_rd_valid(rd_valid), .o_record_summary_info(info),
    .o_power_up_count(pwr_cnt), .o_rtc_time(rtc), .o_busy(busy), .o_pending(pending),
    .o_full(full), .i_nv_pwr_cnt(nv_pwr), .i_nv_rec_count(nv_cnt), .i_nv_last_index(nv_last),
    .o_flash(flash), .i_fl_rd_valid(fl_valid), .i_fl_rdata(fl_rdata));
  flash_model i_flash_model (.i_clk(clk), .i_cmd(flash), .o_valid(fl_valid), .o_rdata(fl_rdata));
  // ****************************************
  // shared tasks
  // ****************************************
  // counts program strobes so unit totals and the first address can be judged
  always @(posedge clk) begin
    if (flash.prog === 1'b1) begin
      if (prog_cnt == 0) first_addr = flash.addr;
      prog_cnt++;
    end
    if (flash.erase === 1'b1) erase_addr = flash.addr;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle(input int n);
    for (int k = 0; k < n && busy !== 1'b0; k++) tick(1);
    check(busy, 1'b0);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    tick(4);
    wait_idle(3000);
  endtask
  task automatic read_word(input logic [5:0] idx, input logic [3:0] w, input logic [31:0] exp);
    rd_req = 1'b1;
    rd_index = idx;
    rd_word = w;
    tick(1);
    rd_req = 1'b0;
    for (int k = 0; k < 20 && rd_valid !== 1'b1; k++) tick(1);
    check({rd_valid, readout}, {1'b1, exp});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_powerup();
    check(pwr_cnt, 16'h0042);
    check(info, {8'h06, 8'h05});
    check(rtc < 48'h10, 1'b1);
    $display("test_powerup done");
  endtask
  task automatic test_epoch();
    epoch = 48'h6000_0000_0000;
    epoch_set = 1'b1;
    tick(1);
    epoch_set = 1'b0;
    tick(800);
    // one tick is about 763 cycles, so one tick has passed; two are also accepted
    check((rtc - epoch) inside {48'h1, 48'h2}, 1'b1);
    $display("test_epoch done");
  endtask
  task automatic test_enter_record();
    prog_cnt = 0;
    rec_enter = 1'b1;
    tick(1);
    rec_enter = 1'b0;
    check({pending, link_out.trig, link_out.id}, {2'b11, 32'h1});
    status = ~status; // snapshot must not follow this change
    tick(20);
    check(prog_cnt, 0);
    enter_done = 1'b1;
    tick(1);
    enter_done = 1'b0;
    tick(3);
    wait_idle(40000);
    check({prog_cnt[7:0], first_addr}, {8'd16, 16'h1180});
    check(info, {8'h07, 8'h06});
    read_word(6'd6, 4'd0, 32'h1);
    read_word(6'd6, 4'd3, 32'h1234_5678);
    $display("test_enter_record done");
  endtask
  task automatic test_link_record();
    cyclic = 1'b1;
    link_in = '{trig: 1'b1, id: 32'h0000_0abc};
    tick(1);
    link_in = '0;
    check({pending, link_out.trig}, 2'b10);
    tick(3);
    wait_idle(40000);
    check(info, {8'h08, 8'h07});
    check(erase_addr, 16'h1200);
    read_word(6'd7, 4'd0, 32'h0000_0abc);
    $display("test_link_record done");
  endtask
  task automatic test_full_refused();
    cyclic = 1'b0;
    nv_cnt = 8'd32;
    nv_pwr = 16'hffff;
    do_reset();
    check({full, pwr_cnt}, {1'b1, 16'hffff});
    prog_cnt = 0;
    supply_loss = 1'b1;
    tick(1);
    supply_loss = 1'b0;
    tick(20);
    check({pending, prog_cnt[7:0]}, 9'h000);
    cyclic = 1'b1;
    tick(1);
    check(full, 1'b0);
    erase_rec = 1'b1;
    tick(1);
    erase_rec = 1'b0;
    tick(2);
    wait_idle(100);
    check(info, 16'h0000);
    prog_cnt = 0;
    rec_loop = 1'b1;
    tick(1);
    rec_loop = 1'b0;
    enter_done = 1'b1; // enter end of this state must not commit a loop record
    tick(1);
    enter_done = 1'b0;
    tick(3);
    check(prog_cnt, 0);
    state_enter = 1'b1;
    tick(1);
    state_enter = 1'b0;
    enter_done = 1'b1;
    tick(1);
    enter_done = 1'b0;
    tick(3);
    check({prog_cnt[7:0], first_addr}, {8'd1, 16'h1000});
    $display("test_full_refused done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // about 80k cycles are needed, so 95k cycles marks a hang
  initial begin
    #1_900_000;
    err_total++;
    wrap_up();
  end
  initial begin
    do_reset();
    test_powerup();
    test_epoch();
    test_enter_record();
    test_link_record();
    test_full_refused();
    wrap_up();
  end
endmodule // fault_record_logger_test
